/* core/efcs_array.sv */
// Byte-wide flash array: main and information blocks
module efcs_array #(
	parameter int MAIN_DEPTH = efcs_pkg::MAIN_DEPTH,
	parameter int INFO_DEPTH = efcs_pkg::INFO_DEPTH
) (
	input  wire logic        core_clk,  // System clock
	input  wire logic        wr_en,     // Write one byte this cycle
	input  wire logic        wr_erase,  // 1 erase to FF, 0 program
	input  wire logic [16:0] wr_addr,   // Bit 16 selects info block
	input  wire logic [7:0]  wr_data,   // Program data
	input  wire logic        rd_en,     // Array enabled for reads
	input  wire logic [16:0] rd_addr,   // Bit 16 selects info block
	output logic      [7:0]  rd_data    // Registered read data
);
	import efcs_pkg::*;

	logic [7:0] main_mem [MAIN_DEPTH];
	logic [7:0] info_mem [INFO_DEPTH];

	// ----------------------------------------------------------------
	// Cell update: erase sets ones, program can only clear bits
	// ----------------------------------------------------------------
	wire logic [7:0] main_old = main_mem[wr_addr[15:0]];
	wire logic [7:0] info_old = info_mem[wr_addr[INFO_ADDR_W-1:0]];
	wire logic [7:0] main_new = wr_erase ? ERASED_BYTE : (main_old & wr_data);
	wire logic [7:0] info_new = wr_erase ? ERASED_BYTE : (info_old & wr_data);

	// Write port
	always_ff @(posedge core_clk) begin
		if (wr_en && !wr_addr[16]) begin
			main_mem[wr_addr[15:0]] <= main_new;
		end
		if (wr_en && wr_addr[16]) begin
			info_mem[wr_addr[INFO_ADDR_W-1:0]] <= info_new;
		end
	end

	// Read port, idle at zero while disabled
	always_ff @(posedge core_clk) begin
		if (!rd_en) begin
			rd_data <= 8'h00;
		end else if (rd_addr[16]) begin
			rd_data <= info_mem[rd_addr[INFO_ADDR_W-1:0]];
		end else begin
			rd_data <= main_mem[rd_addr[15:0]];
		end
	end

endmodule : efcs_array

/* core/efcs_pkg.sv */
// Constants and types shared by the flash command sequencer
package efcs_pkg;

	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
	localparam logic [7:0] CMD_PROG_BYTE   = 8'h80;
	localparam logic [7:0] CMD_ERASE_PAGE  = 8'h40;
	localparam logic [7:0] CMD_MASS_ERASE  = 8'h20;
	localparam logic [7:0] CMD_READ_STATUS = 8'h10;
	localparam logic [7:0] CMD_CLR_STATUS  = 8'hA0;
	localparam logic [7:0] CMD_SEL_MAIN    = 8'hB0;
	localparam logic [7:0] CMD_SEL_INFO    = 8'hC0;
	localparam logic [7:0] CMD_RESET_VAL   = 8'hFF;

	// ----------------------------------------------------------------
	// Array geometry and address fields
	// ----------------------------------------------------------------
	localparam int ADDR_W       = 16;
	localparam int DATA_W       = 8;
	localparam int MAIN_DEPTH   = 65536;
	localparam int INFO_DEPTH   = 128;
	localparam int PAGE_LSB     = 9;
	localparam int ROW_LSB      = 6;
	localparam int INFO_ADDR_W  = 7;
	localparam logic [15:0] BOOT_TOP      = 16'h07FF;
	localparam logic [16:0] PAGE_SPAN     = 17'h001FF;
	localparam logic [16:0] INFO_BASE     = 17'h10000;
	localparam logic [16:0] INFO_LAST     = 17'h1007F;
	localparam logic [16:0] MAIN_LAST     = 17'h0FFFF;
	localparam logic [7:0]  ERASED_BYTE   = 8'hFF;

	// ----------------------------------------------------------------
	// Status bit positions
	// ----------------------------------------------------------------
	localparam int ST_BUSY_BIT  = 7;
	localparam int ST_CMD_ERR   = 6;
	localparam int ST_ERASE_ERR = 5;
	localparam int ST_PROG_ERR  = 4;
	localparam int ST_INFO_BIT  = 3;
	localparam int ST_LOCK_BIT  = 2;
	localparam int ST_DONE_BIT  = 1;

	// ----------------------------------------------------------------
	// Pin synchroniser reset levels: ext access n, ate program, protect n
	// ----------------------------------------------------------------
	localparam logic [2:0] PIN_RST = 3'b101;

	// ----------------------------------------------------------------
	// Operation times and derived cycle counts
	// ----------------------------------------------------------------
	localparam int CLK_MHZ          = 100;
	localparam int PROG_TIME_US     = 20;
	localparam int PAGE_ERASE_MS    = 10;
	localparam int MASS_ERASE_MS    = 10;
	localparam int PROG_CYCLES      = PROG_TIME_US * CLK_MHZ;
	localparam int PAGE_ERASE_CYC   = PAGE_ERASE_MS * 1000 * CLK_MHZ;
	localparam int MASS_ERASE_CYC   = MASS_ERASE_MS * 1000 * CLK_MHZ;
	localparam int TMR_W            = 21;

	// ----------------------------------------------------------------
	// Sequencer states, Gray coded in declaration order
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		EFCS_STANDBY   = 3'b000,
		EFCS_RD_ARRAY  = 3'b001,
		EFCS_RD_STATUS = 3'b011,
		EFCS_ARG_PROG  = 3'b010,
		EFCS_ARG_ERASE = 3'b110,
		EFCS_BUSY      = 3'b111
	} efcs_state_t;

endpackage : efcs_pkg

/* core/efcs_sequencer.sv */
// Flash command sequencer: reset control, command decode, busy timing
// Behaviour
// - Erase sets bits to one; programming only clears bits to zero.
// - Main block holds 65536 bytes, info block 128 bytes, both byte wide.
// - A page is 512 bytes; page erase clears every byte of it.
// - Address bits 15..9 page, 8..6 row, 5..0 byte.
// - Block reset asserts on power-on, external access, idle fetch, soft bit.
// - Under block reset the sequencer stands by and ignores all accesses.
// - Releasing block reset enters array read mode.
// - Deasserting the test program pin pulses block reset.
// - Eight-bit write-only command register, FF after power-on, never read.
// - Command taken when write strobe and chip select are both asserted.
// - No command is taken during an argument cycle or while busy.
// - Code FF selects array read mode; reads then return array bytes.
// - Code 80 then address and data write starts byte program.
// - Protected boot block is not programmed.
// - Code 40 then page address write starts page erase.
// - Protected boot block is not page erased.
// - Code 20 mass erases; both blocks if info selected; locked disables.
// - Code 10 reads status; all non-FF commands end in status mode.
// - Code A0 clears the status error bits.
// - Code C0 targets info block, B0 targets main block, sticky.
module efcs_sequencer #(
	parameter int PROG_CYCLES    = efcs_pkg::PROG_CYCLES,
	parameter int PAGE_ERASE_CYC = efcs_pkg::PAGE_ERASE_CYC,
	parameter int MASS_ERASE_CYC = efcs_pkg::MASS_ERASE_CYC
) (
	input  wire logic                        core_clk,              // System clock
	input  wire logic                        reset,                 // Standby plane power-on reset
	input  wire logic                        external_access_pin_n, // External access pin, low active
	input  wire logic                        cpu_idle_fetch,        // Controller idle/sleep in fetch mode
	input  wire logic                        soft_flash_reset,      // Soft flash reset bit
	input  wire logic                        ate_program_pin,       // Production test program pin
	input  wire logic                        boot_protect_in_n,     // Boot block protect, low active
	input  wire logic                        write_strobe_in_n,     // Write strobe, low active
	input  wire logic                        chip_select_in_n,      // Chip select, low active
	input  wire logic [efcs_pkg::ADDR_W-1:0] addr_in,               // Flash address
	input  wire logic [efcs_pkg::DATA_W-1:0] data_in,               // Write data
	output logic      [efcs_pkg::DATA_W-1:0] data_out,              // Read data
	output logic                             busy_out,              // Operation in progress
	output logic                             flash_block_reset_in_n // Block reset, low active
);
	import efcs_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisers: three flops, change taken when 2nd and 3rd agree
	// ----------------------------------------------------------------
	wire logic [2:0] pin_raw = {external_access_pin_n, ate_program_pin, boot_protect_in_n};
	logic [2:0] pin_s1;
	logic [2:0] pin_s2;
	logic [2:0] pin_s3;
	logic [2:0] pin_q;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge core_clk or posedge reset) begin
				if (reset) begin
					pin_s1[gi] <= PIN_RST[gi];
					pin_s2[gi] <= PIN_RST[gi];
					pin_s3[gi] <= PIN_RST[gi];
					pin_q[gi]  <= PIN_RST[gi];
				end else begin
					pin_s1[gi] <= pin_raw[gi];
					pin_s2[gi] <= pin_s1[gi];
					pin_s3[gi] <= pin_s2[gi];
					if (pin_s2[gi] == pin_s3[gi]) begin
						pin_q[gi] <= pin_s3[gi];
					end
				end
			end
		end
	endgenerate

	wire logic ext_n_q   = pin_q[2];
	wire logic ate_q     = pin_q[1];
	wire logic locked    = ~pin_q[0];

	// ----------------------------------------------------------------
	// Block reset generation
	// ----------------------------------------------------------------
	logic ate_prev;
	wire logic ate_release = ate_prev & ~ate_q;
	wire logic next_blk_rst_n = ~(~ext_n_q | cpu_idle_fetch | soft_flash_reset | ate_release);

	// Registered block reset, power-on holds it asserted
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ate_prev               <= 1'b0;
			flash_block_reset_in_n <= 1'b0;
		end else begin
			ate_prev               <= ate_q;
			flash_block_reset_in_n <= next_blk_rst_n;
		end
	end

	wire logic in_standby = ~flash_block_reset_in_n;

	// ----------------------------------------------------------------
	// Write cycle detect: first cycle with strobe and select both low
	// ----------------------------------------------------------------
	logic wr_prev;
	wire logic wr_act = ~write_strobe_in_n & ~chip_select_in_n;
	wire logic wr_go  = wr_act & ~wr_prev & ~in_standby;

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	function automatic logic efcs_cmd_known(input logic [7:0] code);
		efcs_cmd_known = (code == CMD_READ_ARRAY) || (code == CMD_PROG_BYTE) ||
			(code == CMD_ERASE_PAGE) || (code == CMD_MASS_ERASE) ||
			(code == CMD_READ_STATUS) || (code == CMD_CLR_STATUS) ||
			(code == CMD_SEL_MAIN) || (code == CMD_SEL_INFO);
	endfunction : efcs_cmd_known

	efcs_state_t state;
	efcs_state_t next_state;
	logic [7:0]  cmd_code_bits;
	logic        info_sel;
	logic        cmd_err;
	logic        erase_err;
	logic        prog_err;
	logic        op_done;
	logic [16:0] walk_addr;
	logic [16:0] walk_end;
	logic        walk_erase;
	logic        walk_fin;
	logic [7:0]  prog_data;
	logic [TMR_W-1:0] op_timer;

	wire logic cmd_slot = (state == EFCS_RD_ARRAY) || (state == EFCS_RD_STATUS);
	wire logic cmd_take = wr_go & cmd_slot;
	wire logic arg_take = wr_go & ((state == EFCS_ARG_PROG) || (state == EFCS_ARG_ERASE));
	wire logic is_known = efcs_cmd_known(data_in);

	wire logic c_prog   = cmd_take & (data_in == CMD_PROG_BYTE);
	wire logic c_erase  = cmd_take & (data_in == CMD_ERASE_PAGE);
	wire logic c_mass   = cmd_take & (data_in == CMD_MASS_ERASE);
	wire logic c_rdarr  = cmd_take & (data_in == CMD_READ_ARRAY);
	wire logic c_clr    = cmd_take & (data_in == CMD_CLR_STATUS);
	wire logic c_main   = cmd_take & (data_in == CMD_SEL_MAIN);
	wire logic c_info   = cmd_take & (data_in == CMD_SEL_INFO);
	wire logic c_bad    = cmd_take & ~is_known;

	// ----------------------------------------------------------------
	// Argument decode: page, row and byte fields of the address
	// ----------------------------------------------------------------
	wire logic [6:0] arg_page = addr_in[ADDR_W-1:PAGE_LSB];
	wire logic [2:0] arg_row  = addr_in[PAGE_LSB-1:ROW_LSB];
	wire logic [5:0] arg_byte = addr_in[ROW_LSB-1:0];
	wire logic [15:0] arg_addr = {arg_page, arg_row, arg_byte};
	wire logic in_boot   = ~info_sel & (arg_addr <= BOOT_TOP);
	wire logic arg_block = locked & in_boot;
	wire logic mass_block = c_mass & locked;

	// Target byte and page ranges in the merged 17-bit space
	wire logic [16:0] prog_target = info_sel ? {10'h200, arg_addr[INFO_ADDR_W-1:0]} : {1'b0, arg_addr};
	wire logic [16:0] page_start  = info_sel ? INFO_BASE : {1'b0, arg_page, 9'h000};
	wire logic [16:0] page_last   = info_sel ? INFO_LAST : (page_start + PAGE_SPAN);
	wire logic [16:0] mass_last   = info_sel ? INFO_LAST : MAIN_LAST;

	wire logic start_prog  = arg_take & (state == EFCS_ARG_PROG) & ~arg_block;
	wire logic start_erase = arg_take & (state == EFCS_ARG_ERASE) & ~arg_block;
	wire logic start_mass  = c_mass & ~locked;
	wire logic start_op    = start_prog | start_erase | start_mass;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	wire logic op_end = (state == EFCS_BUSY) & walk_fin & (op_timer == '0);

	always_comb begin
		next_state = state;
		unique case (state)
			EFCS_STANDBY: begin
				next_state = EFCS_RD_ARRAY;
			end
			EFCS_RD_ARRAY, EFCS_RD_STATUS: begin
				if (start_mass) begin
					next_state = EFCS_BUSY;
				end else if (c_prog) begin
					next_state = EFCS_ARG_PROG;
				end else if (c_erase) begin
					next_state = EFCS_ARG_ERASE;
				end else if (c_rdarr) begin
					next_state = EFCS_RD_ARRAY;
				end else if (cmd_take) begin
					next_state = EFCS_RD_STATUS;
				end
			end
			EFCS_ARG_PROG, EFCS_ARG_ERASE: begin
				if (start_op) begin
					next_state = EFCS_BUSY;
				end else if (arg_take) begin
					next_state = EFCS_RD_STATUS;
				end
			end
			EFCS_BUSY: begin
				if (op_end) begin
					next_state = EFCS_RD_STATUS;
				end
			end
			default: begin
				next_state = EFCS_STANDBY;
			end
		endcase
	end

	// State register, forced to standby under block reset
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state   <= EFCS_STANDBY;
			wr_prev <= 1'b0;
		end else if (in_standby) begin
			state   <= EFCS_STANDBY;
			wr_prev <= 1'b0;
		end else begin
			state   <= next_state;
			wr_prev <= wr_act;
		end
	end

	// ----------------------------------------------------------------
	// Command register and block select, kept through block reset
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cmd_code_bits <= CMD_RESET_VAL;
			info_sel      <= 1'b0;
		end else begin
			if (cmd_take) begin
				cmd_code_bits <= data_in;
			end
			if (c_info) begin
				info_sel <= 1'b1;
			end else if (c_main) begin
				info_sel <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Status flags: a new error wins over a clear in the same cycle
	// ----------------------------------------------------------------
	wire logic set_erase_err = mass_block | (arg_take & (state == EFCS_ARG_ERASE) & arg_block);
	wire logic set_prog_err  = arg_take & (state == EFCS_ARG_PROG) & arg_block;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cmd_err   <= 1'b0;
			erase_err <= 1'b0;
			prog_err  <= 1'b0;
			op_done   <= 1'b0;
		end else begin
			cmd_err   <= c_bad | (cmd_err & ~c_clr);
			erase_err <= set_erase_err | (erase_err & ~c_clr);
			prog_err  <= set_prog_err | (prog_err & ~c_clr);
			op_done   <= op_end | (op_done & ~start_op);
		end
	end

	// ----------------------------------------------------------------
	// Operation walker and duration timer
	// ----------------------------------------------------------------
	wire logic [16:0] next_walk_addr = start_prog ? prog_target :
		(start_erase ? page_start : (start_mass ? 17'h00000 : walk_addr + 17'h00001));
	wire logic [16:0] next_walk_end  = start_prog ? prog_target :
		(start_erase ? page_last : mass_last);
	wire logic [TMR_W-1:0] next_timer = start_prog ? TMR_W'(PROG_CYCLES) :
		(start_erase ? TMR_W'(PAGE_ERASE_CYC) : TMR_W'(MASS_ERASE_CYC));
	wire logic walk_wr = (state == EFCS_BUSY) & ~walk_fin;
	wire logic walk_last = walk_addr == walk_end;

	// Walker steps one byte a cycle, timer counts down to zero
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			walk_addr  <= 17'h00000;
			walk_end   <= 17'h00000;
			walk_erase <= 1'b0;
			walk_fin   <= 1'b1;
			prog_data  <= 8'hFF;
			op_timer   <= '0;
		end else if (start_op) begin
			walk_addr  <= next_walk_addr;
			walk_end   <= next_walk_end;
			walk_erase <= ~start_prog;
			walk_fin   <= 1'b0;
			prog_data  <= data_in;
			op_timer   <= next_timer;
		end else if (state == EFCS_BUSY) begin
			if (walk_wr) begin
				walk_fin  <= walk_last;
				walk_addr <= walk_last ? walk_addr : next_walk_addr;
			end
			if (op_timer != '0) begin
				op_timer <= op_timer - TMR_W'(1);
			end
		end
	end

	// ----------------------------------------------------------------
	// Array and read path
	// ----------------------------------------------------------------
	wire logic rd_on = state == EFCS_RD_ARRAY;
	wire logic [16:0] rd_addr = info_sel ? {10'h200, addr_in[INFO_ADDR_W-1:0]} : {1'b0, addr_in};
	logic [7:0] arr_data;

	efcs_array u_array (
		.core_clk (core_clk),
		.wr_en    (walk_wr),
		.wr_erase (walk_erase),
		.wr_addr  (walk_addr),
		.wr_data  (prog_data),
		.rd_en    (rd_on),
		.rd_addr  (rd_addr),
		.rd_data  (arr_data)
	);

	// Status byte assembly
	wire logic [7:0] status_byte = (8'h01 << ST_BUSY_BIT) * {7'h00, state == EFCS_BUSY} |
		(8'h01 << ST_CMD_ERR) * {7'h00, cmd_err} |
		(8'h01 << ST_ERASE_ERR) * {7'h00, erase_err} |
		(8'h01 << ST_PROG_ERR) * {7'h00, prog_err} |
		(8'h01 << ST_INFO_BIT) * {7'h00, info_sel} |
		(8'h01 << ST_LOCK_BIT) * {7'h00, locked} |
		(8'h01 << ST_DONE_BIT) * {7'h00, op_done};
	wire logic show_status = (state == EFCS_RD_STATUS) || (state == EFCS_BUSY) ||
		(state == EFCS_ARG_PROG) || (state == EFCS_ARG_ERASE);
	wire logic [7:0] next_data_out = show_status ? status_byte : arr_data;

	// Output registers
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			data_out <= 8'h00;
			busy_out <= 1'b0;
		end else begin
			data_out <= in_standby ? 8'h00 : next_data_out;
			busy_out <= (next_state == EFCS_BUSY) & ~in_standby;
		end
	end

endmodule : efcs_sequencer

/* testbench/efcs_checker.sv */
// Port assertions for the flash command sequencer
module efcs_checker (
	input wire logic                        core_clk,               // Clock
	input wire logic                        reset,                  // Power-on reset
	input wire logic                        external_access_pin_n,  // External access
	input wire logic                        cpu_idle_fetch,         // Idle fetch
	input wire logic                        soft_flash_reset,       // Soft reset bit
	input wire logic                        ate_program_pin,        // Test program pin
	input wire logic                        write_strobe_in_n,      // Write strobe
	input wire logic                        chip_select_in_n,       // Chip select
	input wire logic [efcs_pkg::DATA_W-1:0] data_out,               // Read data
	input wire logic                        busy_out,               // Busy
	input wire logic                        flash_block_reset_in_n  // Block reset
);
	timeunit 1ns;
	timeprecision 100ps;
	import efcs_pkg::*;
	// --------
	// Checks
	// --------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	chk_soft_reset: assert property (soft_flash_reset |=> !flash_block_reset_in_n)
		else $error("soft reset not applied");
	chk_idle_reset: assert property (cpu_idle_fetch |=> !flash_block_reset_in_n)
		else $error("idle fetch reset not applied");
	chk_ext_reset: assert property (!external_access_pin_n [*6] |-> !flash_block_reset_in_n)
		else $error("external access reset not applied");
	chk_ate_pulse: assert property ($fell(ate_program_pin) |-> ##[1:6] !flash_block_reset_in_n)
		else $error("no reset pulse after test pin");
	chk_standby_quiet: assert property (!flash_block_reset_in_n [*3] |-> data_out == 8'h00 && !busy_out)
		else $error("activity during standby");
	chk_busy_cause: assert property ($rose(busy_out) |-> $past(!write_strobe_in_n && !chip_select_in_n))
		else $error("busy without a write");
	chk_busy_min: assert property ($rose(busy_out) |-> busy_out [*8])
		else $error("busy too short");
	chk_busy_end: assert property ($rose(busy_out) |-> ##[8:1000] !busy_out)
		else $error("busy never ends");
	chk_busy_status: assert property (busy_out [*3] |-> data_out[7])
		else $error("status busy bit low");
endmodule : efcs_checker

bind efcs_sequencer efcs_checker i_efcs_checker (.core_clk(core_clk), .reset(reset),
	.external_access_pin_n(external_access_pin_n), .cpu_idle_fetch(cpu_idle_fetch),
	.soft_flash_reset(soft_flash_reset), .ate_program_pin(ate_program_pin),
	.write_strobe_in_n(write_strobe_in_n), .chip_select_in_n(chip_select_in_n), .data_out(data_out),
	.busy_out(busy_out), .flash_block_reset_in_n(flash_block_reset_in_n));

/* testbench/efcs_sequencer_tb.sv */
// Self-checking bench for the flash command sequencer
module efcs_sequencer_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import efcs_pkg::*;
	logic core_clk = 1'b0, reset = 1'b1, external_access_pin_n = 1'b1, boot_protect_in_n = 1'b1;
	logic cpu_idle_fetch = 1'b0, soft_flash_reset = 1'b0, ate_program_pin = 1'b0;
	logic write_strobe_in_n, chip_select_in_n, busy_out, flash_block_reset_in_n;
	logic [15:0] addr_in, a;
	logic [7:0] data_in, data_out, d1, d2, v;
	logic [6:0] p;
	logic [31:0] seed = 32'd28142;
	int err_count = 0, checks_done = 0, cyc = 0;
	logic [7:0] codes [6] = '{8'h55, CMD_CLR_STATUS, CMD_SEL_INFO, CMD_SEL_MAIN, CMD_READ_ARRAY, CMD_READ_STATUS};
	logic [7:0] masks [6] = '{8'h48, 8'h48, 8'h48, 8'h48, 8'hFF, 8'h48};
	logic [7:0] exps [6] = '{8'h40, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00};
	logic [7:0] ops [3] = '{CMD_PROG_BYTE, CMD_ERASE_PAGE, CMD_MASS_ERASE};
	logic [7:0] errs [3] = '{8'h10, 8'h20, 8'h20};
	// --------
	// Harness
	// --------
	always #5 core_clk = ~core_clk;
	efcs_sequencer #(.PROG_CYCLES(20), .PAGE_ERASE_CYC(600), .MASS_ERASE_CYC(20)) i_efcs_sequencer (
		.core_clk(core_clk), .reset(reset), .external_access_pin_n(external_access_pin_n),
		.cpu_idle_fetch(cpu_idle_fetch), .soft_flash_reset(soft_flash_reset), .ate_program_pin(ate_program_pin),
		.boot_protect_in_n(boot_protect_in_n), .write_strobe_in_n(write_strobe_in_n),
		.chip_select_in_n(chip_select_in_n), .addr_in(addr_in), .data_in(data_in), .data_out(data_out),
		.busy_out(busy_out), .flash_block_reset_in_n(flash_block_reset_in_n));
	efcs_writer_model i_efcs_writer_model (.core_clk(core_clk), .data_out(data_out),
		.write_strobe_in_n(write_strobe_in_n), .chip_select_in_n(chip_select_in_n),
		.addr_in(addr_in), .data_in(data_in));
	// Xorshift source
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// Programming can only clear bits
	function automatic logic [7:0] merge(logic [7:0] o, logic [7:0] n);
		return o & n;
	endfunction : merge
	task chk(string n, logic [7:0] s, logic [7:0] e);
		checks_done++;
		if (s !== e) begin
			$display("[FAIL] %s expected %h seen %h", n, e, s);
			err_count++;
		end
	endtask : chk
	task wait_idle();
		int n;
		n = 0;
		repeat (2) @(posedge core_clk);
		#1;
		while (busy_out !== 1'b0 && n < 2000) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk("busy wait", 8'(n == 2000), 8'h00);
	endtask : wait_idle
	task prog(logic [15:0] ad, logic [7:0] d);
		i_efcs_writer_model.wr(16'h0000, CMD_PROG_BYTE);
		i_efcs_writer_model.wr(ad, d);
		wait_idle();
		i_efcs_writer_model.wr(16'h0000, CMD_READ_ARRAY);
	endtask : prog
	task conclude();
		if (err_count == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude
	// Hang guard
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			conclude();
		end
	end
	// --------
	// Scenarios
	// --------
	initial begin
		repeat (16) @(posedge core_clk);
		#1;
		chk("standby", data_out | 8'(flash_block_reset_in_n), 8'h00);
		reset = 1'b0;
		repeat (6) @(posedge core_clk);
		#1;
		chk("reset release", 8'(flash_block_reset_in_n), 8'h01);
		repeat (2) begin
			p = 7'd4 + 7'(rnd() % 124);
			a = {p, 9'(rnd() % 511)};
			d1 = 8'(rnd());
			d2 = 8'(rnd());
			i_efcs_writer_model.wr(16'h0000, CMD_ERASE_PAGE);
			i_efcs_writer_model.wr(a, 8'h00);
			i_efcs_writer_model.wr(16'h0000, 8'h55);
			wait_idle();
			i_efcs_writer_model.rd(a, v);
			chk("erase status", v & 8'hC2, 8'h02);
			i_efcs_writer_model.wr(16'h0000, CMD_READ_ARRAY);
			i_efcs_writer_model.rd({p, 9'h1FF}, v);
			chk("page top", v, ERASED_BYTE);
			prog(a, d1);
			prog(a, d2);
			i_efcs_writer_model.rd(a, v);
			chk("program", v, merge(d1, d2));
		end
		exps[4] = merge(d1, d2);
		for (int i = 0; i < 6; i++) begin
			i_efcs_writer_model.wr(16'h0000, codes[i]);
			i_efcs_writer_model.rd((i == 4) ? a : 16'(rnd()), v);
			chk("command status", v & masks[i], exps[i]);
		end
		// Erase the boot page first so a wrongly accepted locked write would show
		i_efcs_writer_model.wr(16'h0000, CMD_ERASE_PAGE);
		i_efcs_writer_model.wr(16'h0100, 8'h00);
		wait_idle();
		boot_protect_in_n = 1'b0;
		repeat (4) @(posedge core_clk);
		for (int i = 0; i < 3; i++) begin
			i_efcs_writer_model.wr(16'h0000, ops[i]);
			if (i < 2)
				i_efcs_writer_model.wr(16'h0100, 8'h00);
			i_efcs_writer_model.rd(16'h0100, v);
			chk("locked op", {v[5:4], v[2], busy_out}, {errs[i][5:4], 2'b10});
			i_efcs_writer_model.wr(16'h0000, CMD_CLR_STATUS);
		end
		i_efcs_writer_model.wr(16'h0000, CMD_READ_ARRAY);
		i_efcs_writer_model.rd(16'h0100, v);
		chk("locked array", v, ERASED_BYTE);
		i_efcs_writer_model.wr(16'h0000, CMD_READ_STATUS);
		boot_protect_in_n = 1'b1;
		soft_flash_reset = 1'b1;
		repeat (3) @(posedge core_clk);
		#1;
		chk("soft reset", 8'(flash_block_reset_in_n), 8'h00);
		soft_flash_reset = 1'b0;
		repeat (6) @(posedge core_clk);
		i_efcs_writer_model.rd(a, v);
		chk("array after reset", v, merge(d1, d2));
		external_access_pin_n = 1'b0;
		repeat (8) @(posedge core_clk);
		#1;
		external_access_pin_n = 1'b1;
		cpu_idle_fetch = 1'b1;
		@(posedge core_clk);
		#1;
		cpu_idle_fetch = 1'b0;
		ate_program_pin = 1'b1;
		repeat (6) @(posedge core_clk);
		#1;
		ate_program_pin = 1'b0;
		repeat (12) @(posedge core_clk);
		conclude();
	end
endmodule : efcs_sequencer_tb

/* testbench/efcs_writer_model.sv */
// Model of the command writer on the sequencer bus
module efcs_writer_model (
	input  wire logic                        core_clk,          // Clock
	input  wire logic [efcs_pkg::DATA_W-1:0] data_out,          // Read data
	output logic                             write_strobe_in_n, // Write strobe
	output logic                             chip_select_in_n,  // Chip select
	output logic      [efcs_pkg::ADDR_W-1:0] addr_in,           // Address
	output logic      [efcs_pkg::DATA_W-1:0] data_in            // Write data
);
	timeunit 1ns;
	timeprecision 100ps;
	import efcs_pkg::*;
	// Idle bus
	initial begin
		{write_strobe_in_n, chip_select_in_n} = 2'b11;
		addr_in = 16'h0000;
		data_in = 8'h00;
	end
	// One write cycle; released lines show the inverse so stale values never match
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		#1;
		addr_in = a;
		data_in = d;
		{write_strobe_in_n, chip_select_in_n} = 2'b00;
		@(posedge core_clk);
		#1;
		{write_strobe_in_n, chip_select_in_n} = 2'b11;
		addr_in = ~a;
		data_in = ~d;
	endtask : wr
	// Read: hold the address until registered data has settled
	task rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge core_clk);
		#1;
		addr_in = a;
		repeat (3) @(posedge core_clk);
		#1;
		d = data_out;
	endtask : rd
endmodule : efcs_writer_model
